// ---- hdl/codec_revision_analog_special_regs.sv ----
// Purpose: Revision and analog special registers behind an AHB-Lite slave.
// Assumes: Single whole-word transfers; this is the only slave on hready.
// Notes:   Writes take no wait state, reads take one.
//
// How it works
// (R1) Revision register visible only on page zero.
// (R2) Analog special register visible only on page zero.
// (R3) Upper revision byte: read-only minor, resets zero.
// (R4) Lower revision byte: read-only major, write-proof.
// (R5) Mix bit, reset high, adds DAC to record.
// (R6) Mix bit matters only for mix sources.
// (R7) Stereo mix recording follows 3D enable.
// (R8) Maximum attenuation mutes unless fix disabled.
// (R9) Slot field picks 3/4, 7/8, 6/9, 10/11.
// (R10) Boost and step give 0-30 dB gain.
// (R11) Override enable replaces supply detect result.
// (R12) Override value: zero 3.3 V, one 5 V.
// (R13) Unused analog special bits read as zero.
// (R14) Read-only writes ignored; reset restores defaults.
`timescale 1ns/1ns
module codec_revision_analog_special_regs
#(
   parameter logic [7:0] MAJOR_REV = 8'h01, // Arbitrary neutral value.
   parameter logic [7:0] MINOR_REV = codec_special_pkg::MINOR_RESET
)
(
   input  wire logic        clk_sys,      // System clock, 125 MHz.
   input  wire logic        arst_n,       // Asynchronous reset, low.
   input  wire logic        hsel,         // Slave select.
   input  wire logic [31:0] haddr,        // Byte address.
   input  wire logic [1:0]  htrans,       // Transfer type.
   input  wire logic        hwrite,       // Write when high.
   input  wire logic [2:0]  hsize,        // Transfer size, word only.
   input  wire logic [31:0] hwdata,       // Write data.
   input  wire logic        hready,       // Bus ready.
   output logic [31:0]      hrdata,       // Read data, registered.
   output logic             hreadyout,    // Slave ready.
   output logic             hresp,        // Always OKAY.
   input  wire logic [2:0]  recSource,    // Record source selection.
   input  wire logic        threeDEnable, // 3D effects enable.
   input  wire logic        micBoost,     // Mic boost enable bit.
   input  wire logic [4:0]  attenLeft,    // Left attenuation code.
   input  wire logic [4:0]  attenRight,   // Right attenuation code.
   input  wire logic        detect5V,     // Supply detector result.
   output logic             dacInRecord,  // DAC in record mix.
   output logic             recordMix3d,  // Stereo mix carries 3D.
   output logic             muteLeft,     // Left fully muted.
   output logic             muteRight,    // Right fully muted.
   output logic [3:0]       adcSlotLeft,  // Left ADC link slot.
   output logic [3:0]       adcSlotRight, // Right ADC link slot.
   output logic [1:0]       micGainCode,  // Mic gain steps.
   output logic             supply5V      // 5 V analog mode.
);
   import codec_special_pkg::*;

   bus_state_e           state;      // Data phase tracker.
   bus_state_e           next_state; // Next phase.
   logic [31:0]          dpAddr;     // Address held for the data phase.
   logic [PAGE_W-1:0]    pageSel;    // Page selector.
   logic                 mixDac;     // Record mix includes DAC.
   logic                 muteFixDis; // Mute fix disabled.
   logic [1:0]           slotSel;    // ADC slot placement.
   logic                 micStep;    // Extra mic gain step.
   logic                 ovrEn;      // Supply override enable.
   logic                 ovrVal;     // Supply override value.
   special_ctrl_if       ctl ();     // Fields to the effects logic.

   // Address phase is taken only for NONSEQ/SEQ with the bus ready.
   wire addrTaken = hsel & htrans[1] & hready;
   wire pageZero  = (pageSel == PAGE_ZERO);
   // Both vendor registers hide behind page zero. [R1]
   wire hitRev  = (dpAddr == ADDR_REV) & pageZero;
   wire hitAsp  = (dpAddr == ADDR_ASP) & pageZero; // [R2]
   wire hitPage = (dpAddr == ADDR_PAGE);
   wire wrPhase = (state == BUS_WRITE);
   // Revision has no write path at all, so writes there vanish. [R14]
   wire wrAsp  = wrPhase & hitAsp;
   wire wrPage = wrPhase & hitPage;
   // Only the documented bits are kept; the rest cannot be set. [R13]
   wire [15:0] wrAspData = hwdata[15:0] & ASP_WMASK;
   wire [15:0] aspValue = {3'h0, mixDac, 5'h00, muteFixDis, slotSel,
                           1'b0, micStep, ovrEn, ovrVal}; // [R13]
   wire [15:0] revValue = {MINOR_REV, MAJOR_REV}; // [R3] [R4]
   // Read mux; unmapped or hidden registers read zero.
   wire [31:0] readMux =
      hitRev  ? {16'h0000, revValue} :
      hitAsp  ? {16'h0000, aspValue} :
      hitPage ? {{(32-PAGE_W){1'b0}}, pageSel} : 32'h00000000;

   // Reads stall one cycle so that hrdata comes from a flop.
   assign hreadyout = (state != BUS_RDWAIT);
   assign hresp     = 1'b0;

   // Phase sequencing; a read wait always finishes before a new take.
   always_comb
   begin
      case (state)
         BUS_RDWAIT: next_state = BUS_RDDONE;
         BUS_IDLE, BUS_WRITE, BUS_RDDONE:
            next_state = !addrTaken ? BUS_IDLE :
                         hwrite ? BUS_WRITE : BUS_RDWAIT;
         default:    next_state = BUS_IDLE;
      endcase
   end

   // Phase register and held address.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state  <= BUS_IDLE;
         dpAddr <= 32'h00000000;
      end
      else
      begin
         state <= next_state;
         if (addrTaken)
            dpAddr <= haddr;
      end
   end

   // Read data is captured at the end of the wait cycle.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         hrdata <= 32'h00000000;
      else if (state == BUS_RDWAIT)
         hrdata <= readMux;
   end

   // Page selector; any page other than zero hides both registers.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         pageSel <= PAGE_ZERO;
      else if (wrPage)
         pageSel <= hwdata[PAGE_W-1:0];
   end

   // Analog special fields; reset restores 1000h. [R14]
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mixDac     <= ASP_RESET[POS_MIX]; // [R5]
         muteFixDis <= ASP_RESET[POS_MUTEFIX];
         slotSel    <= ASP_RESET[POS_SLOT +: 2];
         micStep    <= ASP_RESET[POS_MIC];
         ovrEn      <= ASP_RESET[POS_OVR_EN];
         ovrVal     <= ASP_RESET[POS_OVR_VAL];
      end
      else if (wrAsp) // [R2]
      begin
         mixDac     <= wrAspData[POS_MIX];
         muteFixDis <= wrAspData[POS_MUTEFIX];
         slotSel    <= wrAspData[POS_SLOT +: 2];
         micStep    <= wrAspData[POS_MIC];
         ovrEn      <= wrAspData[POS_OVR_EN];
         ovrVal     <= wrAspData[POS_OVR_VAL];
      end
   end

   // Hand the fields over to the effects logic.
   assign ctl.mixDac         = mixDac;
   assign ctl.muteFixDisable = muteFixDis;
   assign ctl.slotSel        = slotSel;
   assign ctl.micStep        = micStep;
   assign ctl.ovrEn          = ovrEn;
   assign ctl.ovrVal         = ovrVal;

   // Control levels toward the analog front end.
   analog_special_effects u_effects
   (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .ctl          (ctl),
      .recSource    (recSource),
      .threeDEnable (threeDEnable),
      .micBoost     (micBoost),
      .attenLeft    (attenLeft),
      .attenRight   (attenRight),
      .detect5V     (detect5V),
      .dacInRecord  (dacInRecord),
      .recordMix3d  (recordMix3d),
      .muteLeft     (muteLeft),
      .muteRight    (muteRight),
      .adcSlotLeft  (adcSlotLeft),
      .adcSlotRight (adcSlotRight),
      .micGainCode  (micGainCode),
      .supply5V     (supply5V)
   );

   // A read of a hidden revision register returns zero.
   chk_rev_page_gate: assert property (@(posedge clk_sys) // [R1]
      disable iff (!arst_n)
      (state == BUS_RDWAIT && dpAddr == ADDR_REV && !pageZero) |=>
      hrdata == 32'h00000000)
      else $error("Revision readable off page zero");
   // A write while another page is selected leaves the fields alone.
   chk_asp_page_gate: assert property (@(posedge clk_sys) // [R2]
      disable iff (!arst_n)
      (wrPhase && dpAddr == ADDR_ASP && !pageZero) |=> $stable(aspValue))
      else $error("Analog special written off page zero");
   chk_minor_field: assert property (@(posedge clk_sys) // [R3]
      disable iff (!arst_n) (state == BUS_RDWAIT && hitRev) ##1
      hreadyout |-> hrdata[15:8] == MINOR_REV)
      else $error("Minor revision read wrong");
   chk_major_field: assert property (@(posedge clk_sys) // [R4]
      disable iff (!arst_n) (state == BUS_RDWAIT && hitRev) |=>
      hrdata[7:0] == MAJOR_REV && hrdata[31:16] == 16'h0000)
      else $error("Major revision read wrong");
   chk_reserved_zero: assert property (@(posedge clk_sys) // [R13]
      disable iff (!arst_n) (state == BUS_RDWAIT && hitAsp) |=>
      (hrdata & ~{16'h0000, ASP_WMASK}) == 32'h00000000)
      else $error("Reserved analog special bits nonzero");
   chk_mix_write: assert property (@(posedge clk_sys) // [R5]
      disable iff (!arst_n) wrAsp |=> mixDac == $past(hwdata[POS_MIX]))
      else $error("Mix bit not written");
   chk_read_wait: assert property (@(posedge clk_sys) // Reads take exactly one wait state.
      disable iff (!arst_n) (addrTaken && !hwrite) |=>
      !hreadyout ##1 hreadyout)
      else $error("Read wait is not exactly one cycle");
   cov_rev_read: cover property (@(posedge clk_sys)
      disable iff (!arst_n) state == BUS_RDWAIT && hitRev);
   cov_asp_write: cover property (@(posedge clk_sys)
      disable iff (!arst_n) wrAsp);
   cov_hidden_write: cover property (@(posedge clk_sys)
      disable iff (!arst_n) wrPhase && dpAddr == ADDR_ASP && !pageZero);
endmodule

// ---- hdl/codec_special_pkg.sv ----
// Purpose: Shared constants for the codec revision and analog special block.
// Assumes: Register indices are scaled by four to form AHB byte addresses.
// Notes:   Fields are 16 bits wide and sit in the low half of each word.
package codec_special_pkg;
   // Register indices as printed, and the byte addresses derived from them.
   localparam logic [7:0]  IDX_PAGE = 8'h24;
   localparam logic [7:0]  IDX_REV  = 8'h6C;
   localparam logic [7:0]  IDX_ASP  = 8'h6E;
   localparam logic [31:0] ADDR_PAGE = {22'h000000, IDX_PAGE, 2'h0};
   localparam logic [31:0] ADDR_REV  = {22'h000000, IDX_REV, 2'h0};
   localparam logic [31:0] ADDR_ASP  = {22'h000000, IDX_ASP, 2'h0};
   // Page selector width and the page that exposes both registers.
   localparam int          PAGE_W    = 4;
   localparam logic [3:0]  PAGE_ZERO = 4'h0;
   // Revision fields; minor resets to zero.
   localparam logic [7:0]  MINOR_RESET = 8'h00;
   // Analog special field positions.
   localparam int POS_MIX     = 12;
   localparam int POS_MUTEFIX = 6;
   localparam int POS_SLOT    = 4;
   localparam int POS_MIC     = 2;
   localparam int POS_OVR_EN  = 1;
   localparam int POS_OVR_VAL = 0;
   // Reset value and the mask of bits that software may hold.
   localparam logic [15:0] ASP_RESET = 16'h1000;
   localparam logic [15:0] ASP_WMASK = 16'h1077;
   // Attenuation code that is treated as full mute.
   localparam logic [4:0]  ATTEN_MAX = 5'h1F;
   // Record source codes that select a mix.
   localparam logic [2:0]  REC_STEREO_MIX = 3'h5;
   localparam logic [2:0]  REC_MONO_MIX   = 3'h6;
   // Slot numbers for the four ADC placements, left then right.
   localparam logic [3:0]  SLOT_L0 = 4'h3;
   localparam logic [3:0]  SLOT_R0 = 4'h4;
   localparam logic [3:0]  SLOT_L1 = 4'h7;
   localparam logic [3:0]  SLOT_R1 = 4'h8;
   localparam logic [3:0]  SLOT_L2 = 4'h6;
   localparam logic [3:0]  SLOT_R2 = 4'h9;
   localparam logic [3:0]  SLOT_L3 = 4'hA;
   localparam logic [3:0]  SLOT_R3 = 4'hB;
   // Bus slave phases, one-hot.
   typedef enum logic [3:0] {
      BUS_IDLE   = 4'b0001,
      BUS_WRITE  = 4'b0010,
      BUS_RDWAIT = 4'b0100,
      BUS_RDDONE = 4'b1000
   } bus_state_e;
endpackage

// ---- hdl/special_ctrl_if.sv ----
// Purpose: Carries the analog special control fields to the effects logic.
// Assumes: Driven only by the register bank.
// Notes:   Plain levels, no handshake.
`timescale 1ns/1ns
interface special_ctrl_if;
   logic       mixDac;          // DAC joins the record mix.
   logic       muteFixDisable;  // Maximum attenuation no longer mutes.
   logic [1:0] slotSel;         // ADC slot placement code.
   logic       micStep;         // Extra microphone gain step.
   logic       ovrEn;           // Supply detect override enable.
   logic       ovrVal;          // Supply override value.
   // The register bank owns the fields.
   modport bank (output mixDac, muteFixDisable, slotSel, micStep,
                 ovrEn, ovrVal);
   // The effects logic only reads them.
   modport fx (input mixDac, muteFixDisable, slotSel, micStep,
               ovrEn, ovrVal);
endinterface

// ---- hdl/analog_special_effects.sv ----
// Purpose: Turns the analog special controls into codec control levels.
// Assumes: Side inputs come from other codec registers and the detector.
// Notes:   All outputs are registered, so they lag a control by one edge.
`timescale 1ns/1ns
module analog_special_effects
   import codec_special_pkg::*;
(
   input  wire logic       clk_sys,        // System clock.
   input  wire logic       arst_n,         // Asynchronous reset, low.
   special_ctrl_if.fx      ctl,            // Control fields.
   input  wire logic [2:0] recSource,      // Record source selection.
   input  wire logic       threeDEnable,   // 3D effects enable.
   input  wire logic       micBoost,       // Mic boost enable bit.
   input  wire logic [4:0] attenLeft,      // Left attenuation code.
   input  wire logic [4:0] attenRight,     // Right attenuation code.
   input  wire logic       detect5V,       // Supply detector says 5 V.
   output logic            dacInRecord,    // DAC is in the record mix.
   output logic            recordMix3d,    // Stereo mix carries 3D effect.
   output logic            muteLeft,       // Left channel fully muted.
   output logic            muteRight,      // Right channel fully muted.
   output logic [3:0]      adcSlotLeft,    // Link slot for left ADC.
   output logic [3:0]      adcSlotRight,   // Link slot for right ADC.
   output logic [1:0]      micGainCode,    // 0..3 steps of 10 dB.
   output logic            supply5V        // Analog runs in 5 V mode.
);
   // Decodes are named wires so that each output flop stays trivial.
   wire mixSrc = (recSource == REC_STEREO_MIX)
               | (recSource == REC_MONO_MIX);
   // Outside a mix source the bit is inert. [R6]
   wire next_dacIn = ctl.mixDac & mixSrc; // [R5]
   wire next_mix3d = threeDEnable & (recSource == REC_STEREO_MIX); // [R7]
   wire next_muteL = ~ctl.muteFixDisable & (attenLeft == ATTEN_MAX); // [R8]
   wire next_muteR = ~ctl.muteFixDisable & (attenRight == ATTEN_MAX);
   wire [1:0] next_mic = {micBoost, ctl.micStep}; // [R10]
   // Override replaces the detector result outright. [R11]
   wire next_s5 = ctl.ovrEn ? ctl.ovrVal : detect5V; // [R12]
   logic [3:0] next_slotL;
   logic [3:0] next_slotR;

   // Slot table; default keeps the standard pair.
   always_comb
   begin
      case (ctl.slotSel) // [R9]
         2'h1:    begin next_slotL = SLOT_L1; next_slotR = SLOT_R1; end
         2'h2:    begin next_slotL = SLOT_L2; next_slotR = SLOT_R2; end
         2'h3:    begin next_slotL = SLOT_L3; next_slotR = SLOT_R3; end
         default: begin next_slotL = SLOT_L0; next_slotR = SLOT_R0; end
      endcase
   end

   // Output flops.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dacInRecord  <= 1'b0;
         recordMix3d  <= 1'b0;
         muteLeft     <= 1'b0;
         muteRight    <= 1'b0;
         adcSlotLeft  <= SLOT_L0;
         adcSlotRight <= SLOT_R0;
         micGainCode  <= 2'h0;
         supply5V     <= 1'b0;
      end
      else
      begin
         dacInRecord  <= next_dacIn;
         recordMix3d  <= next_mix3d;
         muteLeft     <= next_muteL;
         muteRight    <= next_muteR;
         adcSlotLeft  <= next_slotL;
         adcSlotRight <= next_slotR;
         micGainCode  <= next_mic;
         supply5V     <= next_s5;
      end
   end

   chk_mix_source_gate: assert property (@(posedge clk_sys) // [R6]
      disable iff (!arst_n) !mixSrc |=> !dacInRecord)
      else $error("DAC entered record mix outside a mix source");
   chk_mute_at_max: assert property (@(posedge clk_sys) // [R8]
      disable iff (!arst_n)
      (attenLeft == ATTEN_MAX && !ctl.muteFixDisable) |=> muteLeft)
      else $error("Maximum attenuation did not mute left channel");
   chk_slot_code_three: assert property (@(posedge clk_sys) // [R9]
      disable iff (!arst_n) ctl.slotSel == 2'h3 |=>
      adcSlotLeft == 4'hA && adcSlotRight == 4'hB)
      else $error("Slot code three gave wrong slots");
   chk_mic_gain_pair: assert property (@(posedge clk_sys) // [R10]
      disable iff (!arst_n) micBoost && !ctl.micStep |=>
      micGainCode == 2'h2)
      else $error("Boost alone did not give 20 dB");
   chk_supply_override: assert property (@(posedge clk_sys) // [R11]
      disable iff (!arst_n) ctl.ovrEn && (ctl.ovrVal != detect5V) |=>
      supply5V == $past(ctl.ovrVal))
      else $error("Supply override not applied");
   chk_stereo_3d: assert property (@(posedge clk_sys) // [R7]
      disable iff (!arst_n) recSource == REC_STEREO_MIX |=>
      recordMix3d == $past(threeDEnable))
      else $error("Stereo mix ignores 3D enable");
   cov_override_5v: cover property (@(posedge clk_sys)
      disable iff (!arst_n) ctl.ovrEn ##1 supply5V);
endmodule

// ---- sim/host_bus_model.sv ----
// Purpose: Host side AHB-Lite master for the codec register block.
// Assumes: One slave, whose hreadyout comes back as hready.
// Notes:   Tasks are entered just after a rising edge and end on one.
`timescale 1ns/1ns
module host_bus_model
(
   input  wire logic   clk_sys,  // System clock.
   input  wire logic   hready,   // Bus ready.
   output logic        hsel,     // Slave select.
   output logic [31:0] haddr,    // Byte address.
   output logic [1:0]  htrans,   // Transfer type.
   output logic        hwrite,   // Write when high.
   output logic [2:0]  hsize,    // Always a whole word.
   output logic [31:0] hwdata,   // Write data.
   output logic        hung      // A wait for hready ran out.
);
   // Idle bus at time zero.
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      hung = 1'b0;
   end

   // Waits for hready at a rising edge; a hang is flagged, not waited out.
   task automatic wait_ready();
      int n;
      begin
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end while (hready !== 1'b1 && n < 64);
         if (hready !== 1'b1)
            hung <= 1'b1;
      end
   endtask

   // One single word transfer; read data is taken by the bench monitor.
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= a;
         htrans <= 2'h2;
         hwrite <= wr;
         wait_ready();
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         wait_ready();
      end
   endtask
endmodule

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the revision and analog special block.
// Assumes: hready is the slave's own hreadyout.
// Notes:   Read data are compared by a monitor against queued notes.
`timescale 1ns/1ns
module testbench;
   import codec_special_pkg::*;
   localparam logic [7:0]  MAJOR_T = 8'h5A;          // Arbitrary value.
   localparam logic [31:0] ADDR_FREE = 32'h00000004; // Unmapped word.
   logic clk_sys, arst_n, hsel, hwrite, hresp, hreadyout, hung;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans, micGainCode;
   logic [2:0]  hsize, recSource;
   logic threeDEnable, micBoost, detect5V, dacInRecord, recordMix3d;
   logic muteLeft, muteRight, rdPend, supply5V;
   logic [4:0]  attenLeft, attenRight;
   logic [3:0]  adcSlotLeft, adcSlotRight;
   logic [15:0] sideNow;
   logic [31:0] expQ[$];
   int n_errors, tests_run, seed;

   // All side outputs plus hresp, which must stay OKAY.
   assign sideNow = {hresp, dacInRecord, recordMix3d, muteLeft, muteRight,
                     adcSlotLeft, adcSlotRight, micGainCode, supply5V};

   codec_revision_analog_special_regs #(.MAJOR_REV(MAJOR_T)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .recSource(recSource), .threeDEnable(threeDEnable),
      .micBoost(micBoost), .attenLeft(attenLeft), .attenRight(attenRight),
      .detect5V(detect5V), .dacInRecord(dacInRecord),
      .recordMix3d(recordMix3d), .muteLeft(muteLeft),
      .muteRight(muteRight), .adcSlotLeft(adcSlotLeft),
      .adcSlotRight(adcSlotRight), .micGainCode(micGainCode),
      .supply5V(supply5V));

   host_bus_model host (
      .clk_sys(clk_sys), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hung(hung));

   // 125 MHz clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      begin
         $display("counts: %0d compared, %0d mismatched", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // Compares one read word with its note.
   task automatic check_word(input logic [31:0] e, input logic [31:0] s);
      begin
         tests_run++;
         if (s !== e)
         begin
            n_errors++;
            $display("mismatch read word expected %h seen %h", e, s);
         end
      end
   endtask

   // Side outputs expected from a register value and the present inputs.
   function automatic logic [15:0] exp_side(input logic [15:0] a);
      logic       mix;
      logic [7:0] slots;
      begin
         mix = (recSource == REC_STEREO_MIX) || (recSource == REC_MONO_MIX);
         case (a[5:4])
            2'h0:    slots = 8'h34;
            2'h1:    slots = 8'h78;
            2'h2:    slots = 8'h69;
            default: slots = 8'hAB;
         endcase
         exp_side = {1'b0, a[POS_MIX] & mix,
                     threeDEnable & (recSource == REC_STEREO_MIX),
                     ~a[POS_MUTEFIX] & (attenLeft == ATTEN_MAX),
                     ~a[POS_MUTEFIX] & (attenRight == ATTEN_MAX), slots,
                     micBoost, a[POS_MIC],
                     a[POS_OVR_EN] ? a[POS_OVR_VAL] : detect5V};
      end
   endfunction

   // Lets a write reach the registered outputs, then compares them.
   task automatic check_side(input logic [15:0] a);
      logic [15:0] e;
      begin
         repeat (2) @(posedge clk_sys);
         e = exp_side(a);
         tests_run++;
         if (sideNow !== e)
         begin
            n_errors++;
            $display("mismatch side outputs expected %h seen %h", e, sideNow);
         end
      end
   endtask

   // Notes the expected word, then makes the read.
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      begin
         expQ.push_back(e);
         host.xfer(1'b0, a, 32'h00000000);
      end
   endtask

   // Monitor: a read's data phase ends when hready is sampled high.
   always @(posedge clk_sys)
   begin
      if (rdPend && hreadyout === 1'b1)
      begin
         rdPend <= 1'b0;
         if (expQ.size() == 0)
            check_word(32'hDEADBEEF, hrdata);
         else
            check_word(expQ.pop_front(), hrdata);
      end
      if (hsel && htrans[1] && !hwrite && hreadyout)
         rdPend <= 1'b1;
   end

   // A bus hang counts as a mismatch and closes the run.
   always @(posedge hung)
   begin
      n_errors++;
      $display("mismatch hready expected 1 seen %b", hreadyout);
      print_verdict();
   end

   initial
   begin
      seed = 32'h46f0dcf4;
      n_errors = 0;
      tests_run = 0;
      rdPend = 1'b0;
      arst_n = 1'b0;
      recSource = REC_STEREO_MIX;
      threeDEnable = 1'b1;
      micBoost = 1'b0;
      detect5V = 1'b1;
      attenLeft = ATTEN_MAX;
      attenRight = 5'h00;
      repeat (20) @(posedge clk_sys);
      // Release between edges, so that no flop is still held in reset at
      // an edge where the design's assertions are already armed.
      @(negedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      // Reset values, read-only fields and reserved bits.
      rd(ADDR_ASP, {16'h0000, ASP_RESET});
      rd(ADDR_REV, {16'h0000, MINOR_RESET, MAJOR_T});
      check_side(ASP_RESET);
      host.xfer(1'b1, ADDR_ASP, 32'hFFFFFFFF);
      rd(ADDR_ASP, {16'h0000, ASP_WMASK});
      host.xfer(1'b1, ADDR_REV, 32'hFFFFFFFF);
      rd(ADDR_REV, {16'h0000, MINOR_RESET, MAJOR_T});
      host.xfer(1'b1, ADDR_FREE, 32'hFFFFFFFF);
      rd(ADDR_FREE, 32'h00000000);
      $display("test reset and read-only done");
      // Another page hides both registers and blocks writes.
      host.xfer(1'b1, ADDR_PAGE, 32'h00000001);
      rd(ADDR_PAGE, 32'h00000001);
      rd(ADDR_REV, 32'h00000000);
      host.xfer(1'b1, ADDR_ASP, 32'h00000000);
      rd(ADDR_ASP, 32'h00000000);
      host.xfer(1'b1, ADDR_PAGE, 32'h00000000);
      rd(ADDR_ASP, {16'h0000, ASP_WMASK});
      $display("test paging done");
      // Every slot code, gain step and record source with random data.
      for (int i = 0; i < 16; i++)
      begin
         v = $random(seed);
         v[5:4] = i[1:0];
         v[POS_MIC] = i[2];
         recSource <= i[2:0];
         micBoost <= i[3];
         threeDEnable <= v[20];
         detect5V <= v[21];
         attenLeft <= v[22] ? ATTEN_MAX : v[27:23];
         attenRight <= v[28] ? ATTEN_MAX : v[31:27];
         host.xfer(1'b1, ADDR_ASP, v);
         rd(ADDR_ASP, {16'h0000, v[15:0] & ASP_WMASK});
         check_side(v[15:0] & ASP_WMASK);
      end
      $display("test controls done");
      // A reset in mid-run restores the default.
      host.xfer(1'b1, ADDR_ASP, 32'h00000077);
      rd(ADDR_ASP, 32'h00000077);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      rd(ADDR_ASP, {16'h0000, ASP_RESET});
      $display("test second reset done");
      repeat (2) @(posedge clk_sys);
      if (expQ.size() != 0)
      begin
         n_errors++;
         $display("mismatch read queue expected 0 seen %0d", expQ.size());
      end
      print_verdict();
   end
endmodule
